// [verilog/aas_pkg.sv]
// constants, types and register map of the aux adc / analogue setup block
//------------------------------------------------------------------------
// operation
//------------------------------------------------------------------------
// Operation
// - convert only channels enabled in bits 5..0; bits 7..6 are zero
// - enable changes may come any time; they act from next conversion
// - ram-reset bit 6 clears dac0 ram, fill all ones if bit 7 high
// - rate low: adc clock is clk/16, 176 clocks per channel; high doubles
// - first sample after enable takes three periods, later samples one
// - continuous bit high converts enabled channels repeatedly
// - start bit converts once then self-clears; ignored while continuous
// - tx attenuation code 11 is 0dB, 10 is 10dB, 01 and 00 are 20dB
// - offset codes: 10000 mid, 00000 most negative, 11111 most positive
// - in agc hold the host-written gain code is applied
// - in hold, rssi keeps the last self-computed gain, not host gain
// - offset writes act only when allowed; offset reads always work
// - sticky filter overflow flag in bit 6, cleared by read, no irq
// - reads give gain in 7..6 and q offset; i offset in 4..0
// - finished task sets the complete bit; host then reads data words
// - non-zero task runs at a processing gap; code 00 does nothing
// - tasks 01,09,0a,0b set pointer; 0c pokes; 15 loads channel filter
// - task 1a picks tx bt from word 0, default 0.3; 1b sets 0.5
// - task 18 sets the decode threshold from word 0, default 2400
// - 1c sets afc limit, 1d enters eye test, 1f sets rssi averaging
// - data words are byte pairs: word 0 at 1c/1b, word 1 at 1e/1d
// - set-bt value 0 gives 0.3, 1 gives 0.5, 2 gives 0.27
// - eye test mode stays on until reset
package aas_pkg;

	//--------------------------------------------------------------------
	// register indices, byte address is four times the index
	//--------------------------------------------------------------------
	localparam logic [5:0] IDX_ADC_EN = 6'h11;
	localparam logic [5:0] IDX_ADC_CTL = 6'h12;
	localparam logic [5:0] IDX_ATT_IOFS = 6'h18;
	localparam logic [5:0] IDX_AGC_QOFS = 6'h19;
	localparam logic [5:0] IDX_TASK_CMD = 6'h1a;
	localparam logic [5:0] IDX_D0_LO = 6'h1b;
	localparam logic [5:0] IDX_D0_HI = 6'h1c;
	localparam logic [5:0] IDX_D1_LO = 6'h1d;
	localparam logic [5:0] IDX_D1_HI = 6'h1e;
	localparam logic [5:0] IDX_STATUS = 6'h20;

	//--------------------------------------------------------------------
	// field positions
	//--------------------------------------------------------------------
	localparam int CTL_POL = 7;
	localparam int CTL_RAM_RST = 6;
	localparam int CTL_RATE = 2;
	localparam int CTL_CONT = 1;
	localparam int CTL_START = 0;
	localparam int FLD_HI = 7;
	localparam int FLD_LO = 6;
	localparam int OFS_MSB = 4;
	localparam int ST_DONE = 0;
	localparam int ST_PEND = 1;
	localparam int ST_ADC_BUSY = 2;
	localparam int ST_EYE = 3;

	//--------------------------------------------------------------------
	// reset values and timing
	//--------------------------------------------------------------------
	localparam int NUM_CH = 6;
	localparam logic [4:0] OFS_MID = 5'h10;
	localparam logic [15:0] THRESH_DEF = 16'h0960;
	localparam logic [1:0] GAIN_RST = 2'h3;
	localparam int DIV_FAST = 16;
	localparam int DIV_SLOW = 2 * DIV_FAST;
	localparam int CONV_BB_CLKS = 176;
	localparam int TICKS_PER_CONV = CONV_BB_CLKS / DIV_FAST;
	localparam int FIRST_CONVS = 3;

	//--------------------------------------------------------------------
	// types
	//--------------------------------------------------------------------
	typedef enum logic [7:0] {
		CMD_NULL = 8'h00,
		CMD_SET_ADDR = 8'h01,
		CMD_TX_FILT = 8'h09,
		CMD_RX_CHF = 8'h0a,
		CMD_RX_GAUSS = 8'h0b,
		CMD_POKE = 8'h0c,
		CMD_LOAD_CHF = 8'h15,
		CMD_THRESH = 8'h18,
		CMD_SET_BT = 8'h1a,
		CMD_BT05 = 8'h1b,
		CMD_AFC_LIM = 8'h1c,
		CMD_EYE = 8'h1d,
		CMD_RSSI_AVG = 8'h1f
	} aas_cmd_t;

	typedef enum logic [1:0] {
		BT_03 = 2'h0,
		BT_05 = 2'h1,
		BT_027 = 2'h2
	} aas_bt_t;

	typedef enum logic [1:0] {
		ATT_0DB = 2'h0,
		ATT_10DB = 2'h1,
		ATT_20DB = 2'h2
	} aas_atten_t;

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_SCAN = 2'b01,
		S_CONV = 2'b11
	} aas_adc_st_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} aas_wb_req_t;

	typedef struct packed {
		aas_bt_t tx_bt;
		aas_bt_t rx_bt;
		logic [15:0] thresh;
		logic [15:0] afc_limit;
		logic [2:0] rssi_avg;
		logic eye_mode;
	} aas_task_cfg_t;

	typedef struct packed {
		logic stb;
		logic [15:0] addr;
		logic [15:0] data;
	} aas_poke_t;

endpackage : aas_pkg

// [verilog/aas_top.sv]
// aux adc sequencer, analogue setup and task mailbox behind wishbone
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/10ps
module aas_top #(
	parameter int NUM_CH = aas_pkg::NUM_CH,
	parameter logic [15:0] TX_FILT_BASE = 16'h0100,
	parameter logic [15:0] RX_CHF_BASE = 16'h0200,
	parameter logic [15:0] RX_GAUSS_BASE = 16'h0300,
	parameter logic [15:0] AFC_LIMIT_DEF = 16'h0000
) (
	input wire logic CLK,
	input wire logic RST,
	input wire aas_pkg::aas_wb_req_t WB_REQ,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic CHF_OVF,
	input wire logic AGC_HOLD,
	input wire logic [1:0] AGC_AUTO_GAIN,
	input wire logic OFS_WR_OK,
	input wire logic OFS_AUTO_VLD,
	input wire logic [4:0] OFS_AUTO_I,
	input wire logic [4:0] OFS_AUTO_Q,
	input wire logic PROC_GAP,
	output aas_pkg::aas_atten_t TX_ATTEN,
	output logic [1:0] AGC_GAIN,
	output logic [1:0] RSSI_GAIN,
	output logic [4:0] RX_I_OFS,
	output logic [4:0] RX_Q_OFS,
	output logic RAM_CLR,
	output logic RAM_FILL,
	output logic ADC_CLK_EN,
	output logic [2:0] ADC_CHAN,
	output logic ADC_SOC,
	output logic ADC_EOC,
	output logic ADC_BUSY,
	output aas_pkg::aas_task_cfg_t TASK_CFG,
	output logic [15:0] FILT_PTR,
	output aas_pkg::aas_poke_t POKE,
	output logic CHF_LOAD
);

	//--------------------------------------------------------------------
	// bus decode
	//--------------------------------------------------------------------
	function automatic logic hit(input logic [7:0] adr,
		input logic [5:0] idx);
		hit = (adr[7:2] == idx);
	endfunction : hit

	logic ack_ff;
	logic [31:0] dat_ff;
	logic acc;
	logic wr;
	logic rd;
	logic [7:0] wd;

	// effects land on the edge where the master samples ack
	assign acc = WB_REQ.cyc & WB_REQ.stb & ack_ff;
	assign wr = acc & WB_REQ.we & WB_REQ.sel[0];
	assign rd = acc & ~WB_REQ.we;
	assign wd = WB_REQ.dat[7:0];

	//--------------------------------------------------------------------
	// register state
	//--------------------------------------------------------------------
	logic [5:0] adc_en_ff;
	logic rate_ff;
	logic cont_ff;
	logic start_ff;
	logic ram_clr_ff;
	logic ram_fill_ff;
	logic [1:0] att_code_ff;
	aas_pkg::aas_atten_t att_ff;
	logic [4:0] i_ofs_ff;
	logic [4:0] q_ofs_ff;
	logic [1:0] agc_host_ff;
	logic [1:0] agc_out_ff;
	logic [1:0] rssi_gain_ff;
	logic ovf_ff;
	logic [15:0] d0_ff;
	logic [15:0] d1_ff;
	logic pass_done;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			adc_en_ff <= 6'h00;
			rate_ff <= 1'b0;
			cont_ff <= 1'b0;
			start_ff <= 1'b0;
			ram_fill_ff <= 1'b0;
			att_code_ff <= 2'h3;
		end else begin
			if (wr && hit(WB_REQ.adr, aas_pkg::IDX_ADC_EN)) begin
				adc_en_ff <= wd[5:0];
			end
			if (wr && hit(WB_REQ.adr, aas_pkg::IDX_ADC_CTL)) begin
				rate_ff <= wd[aas_pkg::CTL_RATE];
				cont_ff <= wd[aas_pkg::CTL_CONT];
				start_ff <= wd[aas_pkg::CTL_START];
				ram_fill_ff <= wd[aas_pkg::CTL_POL];
			end else if (pass_done) begin
				start_ff <= 1'b0;
			end
			if (wr && hit(WB_REQ.adr, aas_pkg::IDX_ATT_IOFS)) begin
				att_code_ff <= wd[aas_pkg::FLD_HI:aas_pkg::FLD_LO];
			end
		end
	end

	// ram clear is a one-cycle strobe per write with the reset bit set
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ram_clr_ff <= 1'b0;
		end else begin
			ram_clr_ff <= wr && hit(WB_REQ.adr, aas_pkg::IDX_ADC_CTL) &&
				wd[aas_pkg::CTL_RAM_RST];
		end
	end

	// attenuation decode; 01 and 00 share the deepest step
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			att_ff <= aas_pkg::ATT_0DB;
		end else begin
			case (att_code_ff)
				2'h3: att_ff <= aas_pkg::ATT_0DB;
				2'h2: att_ff <= aas_pkg::ATT_10DB;
				default: att_ff <= aas_pkg::ATT_20DB;
			endcase
		end
	end

	//--------------------------------------------------------------------
	// offsets and agc
	//--------------------------------------------------------------------
	// host writes win over the automatic measurement in the same cycle
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			i_ofs_ff <= aas_pkg::OFS_MID;
			q_ofs_ff <= aas_pkg::OFS_MID;
		end else begin
			if (wr && OFS_WR_OK &&
				hit(WB_REQ.adr, aas_pkg::IDX_ATT_IOFS)) begin
				i_ofs_ff <= wd[aas_pkg::OFS_MSB:0];
			end else if (OFS_AUTO_VLD) begin
				i_ofs_ff <= OFS_AUTO_I;
			end
			if (wr && OFS_WR_OK &&
				hit(WB_REQ.adr, aas_pkg::IDX_AGC_QOFS)) begin
				q_ofs_ff <= wd[aas_pkg::OFS_MSB:0];
			end else if (OFS_AUTO_VLD) begin
				q_ofs_ff <= OFS_AUTO_Q;
			end
		end
	end

	// host gain follows the loop until hold, so hold starts bumpless
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			agc_host_ff <= aas_pkg::GAIN_RST;
			agc_out_ff <= aas_pkg::GAIN_RST;
			rssi_gain_ff <= aas_pkg::GAIN_RST;
		end else begin
			if (!AGC_HOLD) begin
				agc_host_ff <= AGC_AUTO_GAIN;
				rssi_gain_ff <= AGC_AUTO_GAIN;
			end else if (wr && hit(WB_REQ.adr, aas_pkg::IDX_AGC_QOFS)) begin
				agc_host_ff <= wd[aas_pkg::FLD_HI:aas_pkg::FLD_LO];
			end
			agc_out_ff <= AGC_HOLD ? agc_host_ff : AGC_AUTO_GAIN;
		end
	end

	// a fresh overflow in the reading cycle survives the clear
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ovf_ff <= 1'b0;
		end else if (CHF_OVF) begin
			ovf_ff <= 1'b1;
		end else if (rd && hit(WB_REQ.adr, aas_pkg::IDX_ATT_IOFS)) begin
			ovf_ff <= 1'b0;
		end
	end

	//--------------------------------------------------------------------
	// data words
	//--------------------------------------------------------------------
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			d0_ff <= 16'h0000;
			d1_ff <= 16'h0000;
		end else if (wr) begin
			if (hit(WB_REQ.adr, aas_pkg::IDX_D0_LO)) d0_ff[7:0] <= wd;
			if (hit(WB_REQ.adr, aas_pkg::IDX_D0_HI)) d0_ff[15:8] <= wd;
			if (hit(WB_REQ.adr, aas_pkg::IDX_D1_LO)) d1_ff[7:0] <= wd;
			if (hit(WB_REQ.adr, aas_pkg::IDX_D1_HI)) d1_ff[15:8] <= wd;
		end
	end

	//--------------------------------------------------------------------
	// adc clock divider
	//--------------------------------------------------------------------
	logic [4:0] div_ff;
	logic tick_ff;
	logic [4:0] div_last;

	assign div_last = rate_ff ? 5'(aas_pkg::DIV_SLOW - 1) :
		5'(aas_pkg::DIV_FAST - 1);

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			div_ff <= 5'h00;
			tick_ff <= 1'b0;
		end else if (div_ff >= div_last) begin
			div_ff <= 5'h00;
			tick_ff <= 1'b1;
		end else begin
			div_ff <= div_ff + 5'h01;
			tick_ff <= 1'b0;
		end
	end

	//--------------------------------------------------------------------
	// conversion sequencer
	//--------------------------------------------------------------------
	aas_pkg::aas_adc_st_t st_ff;
	logic [2:0] ch_ff;
	logic [5:0] cnt_ff;
	logic first_ff;
	logic soc_ff;
	logic eoc_ff;
	logic busy_ff;
	logic seq_on;
	logic last_ch;
	logic adv;

	// start bit only counts while continuous mode is off
	assign seq_on = cont_ff | start_ff;
	assign last_ch = (ch_ff == 3'(NUM_CH - 1));
	assign adv = (st_ff == aas_pkg::S_SCAN && seq_on &&
		!adc_en_ff[ch_ff]) ||
		(st_ff == aas_pkg::S_CONV && tick_ff && cnt_ff == 6'h01);
	assign pass_done = adv && last_ch && !cont_ff;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			st_ff <= aas_pkg::S_IDLE;
			ch_ff <= 3'h0;
			cnt_ff <= 6'h00;
			first_ff <= 1'b0;
			soc_ff <= 1'b0;
			eoc_ff <= 1'b0;
		end else begin
			soc_ff <= 1'b0;
			eoc_ff <= 1'b0;
			case (st_ff)
				aas_pkg::S_IDLE: begin
					if (seq_on) begin
						st_ff <= aas_pkg::S_SCAN;
						ch_ff <= 3'h0;
						first_ff <= 1'b1;
					end
				end
				aas_pkg::S_SCAN: begin
					if (!seq_on) begin
						st_ff <= aas_pkg::S_IDLE;
					end else if (adc_en_ff[ch_ff]) begin
						// enable sampled here, so late changes wait a turn
						st_ff <= aas_pkg::S_CONV;
						soc_ff <= 1'b1;
						cnt_ff <= first_ff ?
							6'(aas_pkg::FIRST_CONVS * aas_pkg::TICKS_PER_CONV) :
							6'(aas_pkg::TICKS_PER_CONV);
					end else if (last_ch) begin
						ch_ff <= 3'h0;
						st_ff <= cont_ff ? aas_pkg::S_SCAN :
							aas_pkg::S_IDLE;
					end else begin
						ch_ff <= ch_ff + 3'h1;
					end
				end
				aas_pkg::S_CONV: begin
					if (tick_ff) begin
						if (cnt_ff == 6'h01) begin
							eoc_ff <= 1'b1;
							first_ff <= 1'b0;
							if (last_ch) begin
								ch_ff <= 3'h0;
								st_ff <= cont_ff ? aas_pkg::S_SCAN :
									aas_pkg::S_IDLE;
							end else begin
								ch_ff <= ch_ff + 3'h1;
								st_ff <= aas_pkg::S_SCAN;
							end
						end else begin
							cnt_ff <= cnt_ff - 6'h01;
						end
					end
				end
				default: begin
					st_ff <= aas_pkg::S_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			busy_ff <= 1'b0;
		end else begin
			busy_ff <= (st_ff != aas_pkg::S_IDLE);
		end
	end

	//--------------------------------------------------------------------
	// task mailbox
	//--------------------------------------------------------------------
	aas_pkg::aas_cmd_t cmd_ff;
	logic done_ff;
	logic [15:0] ptr_ff;
	aas_pkg::aas_task_cfg_t cfg_ff;
	aas_pkg::aas_poke_t poke_ff;
	logic chf_load_ff;
	logic cmd_wr;
	logic exec;

	assign cmd_wr = wr && hit(WB_REQ.adr, aas_pkg::IDX_TASK_CMD);
	// a command runs only in a processing gap, never under a new write
	assign exec = (cmd_ff != aas_pkg::CMD_NULL) && PROC_GAP && !cmd_wr;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			cmd_ff <= aas_pkg::CMD_NULL;
			done_ff <= 1'b0;
			ptr_ff <= 16'h0000;
			cfg_ff.tx_bt <= aas_pkg::BT_03;
			cfg_ff.rx_bt <= aas_pkg::BT_03;
			cfg_ff.thresh <= aas_pkg::THRESH_DEF;
			cfg_ff.afc_limit <= AFC_LIMIT_DEF;
			cfg_ff.rssi_avg <= 3'h0;
			cfg_ff.eye_mode <= 1'b0;
			poke_ff <= '0;
			chf_load_ff <= 1'b0;
		end else begin
			poke_ff.stb <= 1'b0;
			chf_load_ff <= 1'b0;
			if (cmd_wr) begin
				cmd_ff <= aas_pkg::aas_cmd_t'(wd);
				done_ff <= 1'b0;
			end else if (exec) begin
				cmd_ff <= aas_pkg::CMD_NULL;
				done_ff <= 1'b1;
				case (cmd_ff)
					aas_pkg::CMD_SET_ADDR: ptr_ff <= d0_ff;
					aas_pkg::CMD_TX_FILT: ptr_ff <= TX_FILT_BASE;
					aas_pkg::CMD_RX_CHF: ptr_ff <= RX_CHF_BASE;
					aas_pkg::CMD_RX_GAUSS: ptr_ff <= RX_GAUSS_BASE;
					aas_pkg::CMD_POKE: begin
						poke_ff.stb <= 1'b1;
						poke_ff.addr <= d0_ff;
						poke_ff.data <= d1_ff;
					end
					aas_pkg::CMD_LOAD_CHF: chf_load_ff <= 1'b1;
					aas_pkg::CMD_THRESH: cfg_ff.thresh <= d0_ff;
					aas_pkg::CMD_SET_BT: begin
						// unlisted values keep the present choice
						case (d0_ff)
							16'h0000: cfg_ff.tx_bt <= aas_pkg::BT_03;
							16'h0001: cfg_ff.tx_bt <= aas_pkg::BT_05;
							16'h0002: cfg_ff.tx_bt <= aas_pkg::BT_027;
							default: cfg_ff.tx_bt <= cfg_ff.tx_bt;
						endcase
					end
					aas_pkg::CMD_BT05: begin
						cfg_ff.tx_bt <= aas_pkg::BT_05;
						cfg_ff.rx_bt <= aas_pkg::BT_05;
					end
					aas_pkg::CMD_AFC_LIM: cfg_ff.afc_limit <= d0_ff;
					aas_pkg::CMD_EYE: cfg_ff.eye_mode <= 1'b1;
					aas_pkg::CMD_RSSI_AVG: cfg_ff.rssi_avg <= d0_ff[2:0];
					default: ptr_ff <= ptr_ff;
				endcase
			end
		end
	end

	//--------------------------------------------------------------------
	// read mux and ack
	//--------------------------------------------------------------------
	logic [7:0] rmux;

	// write-only registers read as zero; mixed ones read back offsets plus overflow or applied gain
	always_comb begin
		rmux = 8'h00;
		if (hit(WB_REQ.adr, aas_pkg::IDX_ATT_IOFS)) begin
			rmux = {1'b0, ovf_ff, 1'b0, i_ofs_ff};
		end else if (hit(WB_REQ.adr, aas_pkg::IDX_AGC_QOFS)) begin
			rmux = {agc_out_ff, 1'b0, q_ofs_ff};
		end else if (hit(WB_REQ.adr, aas_pkg::IDX_D0_LO)) begin
			rmux = d0_ff[7:0];
		end else if (hit(WB_REQ.adr, aas_pkg::IDX_D0_HI)) begin
			rmux = d0_ff[15:8];
		end else if (hit(WB_REQ.adr, aas_pkg::IDX_D1_LO)) begin
			rmux = d1_ff[7:0];
		end else if (hit(WB_REQ.adr, aas_pkg::IDX_D1_HI)) begin
			rmux = d1_ff[15:8];
		end else if (hit(WB_REQ.adr, aas_pkg::IDX_STATUS)) begin
			rmux[aas_pkg::ST_DONE] = done_ff;
			rmux[aas_pkg::ST_PEND] = (cmd_ff != aas_pkg::CMD_NULL);
			rmux[aas_pkg::ST_ADC_BUSY] = busy_ff;
			rmux[aas_pkg::ST_EYE] = cfg_ff.eye_mode;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h00000000;
		end else begin
			ack_ff <= WB_REQ.cyc & WB_REQ.stb & ~ack_ff;
			if (WB_REQ.cyc && WB_REQ.stb && !ack_ff) begin
				dat_ff <= {24'h000000, rmux};
			end
		end
	end

	//--------------------------------------------------------------------
	// outputs, all straight from flops
	//--------------------------------------------------------------------
	assign WB_DAT_O = dat_ff;
	assign WB_ACK_O = ack_ff;
	assign TX_ATTEN = att_ff;
	assign AGC_GAIN = agc_out_ff;
	assign RSSI_GAIN = rssi_gain_ff;
	assign RX_I_OFS = i_ofs_ff;
	assign RX_Q_OFS = q_ofs_ff;
	assign RAM_CLR = ram_clr_ff;
	assign RAM_FILL = ram_fill_ff;
	assign ADC_CLK_EN = tick_ff;
	assign ADC_CHAN = ch_ff;
	assign ADC_SOC = soc_ff;
	assign ADC_EOC = eoc_ff;
	assign ADC_BUSY = busy_ff;
	assign TASK_CFG = cfg_ff;
	assign FILT_PTR = ptr_ff;
	assign POKE = poke_ff;
	assign CHF_LOAD = chf_load_ff;

endmodule : aas_top

// [testbench/aas_host.sv]
// host processor model: classic wishbone master for the register port
`timescale 1ns/10ps
module aas_host (
	input wire logic CLK,
	output aas_pkg::aas_wb_req_t REQ,
	input wire logic [31:0] DAT,
	input wire logic ACK
);
	initial REQ = '0;
	// one access; request held until ack is sampled
	task automatic xfer(input logic we, input logic [5:0] a,
			input logic [7:0] d, output logic [7:0] q);
		@(posedge CLK);
		REQ <= {2'b11, we, a, 2'b00, 4'h1, 24'h0, d};
		do @(posedge CLK); while (ACK !== 1'b1);
		q = DAT[7:0];
		REQ <= '0;
	endtask : xfer
endmodule : aas_host

// [testbench/aas_asserts.sv]
// concurrent checks on the register block ports
`timescale 1ns/10ps
module aas_asserts (
	input wire logic CLK,
	input wire logic RST,
	input wire aas_pkg::aas_wb_req_t WB_REQ,
	input wire logic [31:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	input wire logic AGC_HOLD,
	input wire logic [1:0] AGC_AUTO_GAIN,
	input wire logic [1:0] AGC_GAIN,
	input wire logic [1:0] RSSI_GAIN,
	input wire logic RAM_CLR,
	input wire logic RAM_FILL,
	input wire logic ADC_CLK_EN,
	input wire logic ADC_SOC,
	input wire logic ADC_EOC,
	input wire aas_pkg::aas_task_cfg_t TASK_CFG
);
	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	// past values are junk on the first edge after reset
	logic up_ff;
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) up_ff <= 1'b0;
		else up_ff <= 1'b1;
	end
	wire req = WB_REQ.cyc && WB_REQ.stb;
	wire ctl_wr = req && WB_REQ.we && WB_ACK_O && WB_REQ.sel[0] &&
		WB_REQ.adr[7:2] == aas_pkg::IDX_ADC_CTL;
	sequence s_quiet; (!ADC_EOC)[*8]; endsequence
	property p_ack; req && !WB_ACK_O |=> WB_ACK_O; endproperty
	a_ack: assert property (p_ack) else $error("late ack");
	property p_pulse; WB_ACK_O |=> !WB_ACK_O; endproperty
	a_pulse: assert property (p_pulse) else $error("long ack");
	property p_hi; WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0; endproperty
	a_hi: assert property (p_hi) else $error("upper data");
	property p_clr; ctl_wr && WB_REQ.dat[6] |=> RAM_CLR; endproperty
	a_clr: assert property (p_clr) else $error("no ram clear");
	property p_fill;
		ctl_wr |=> RAM_FILL == $past(WB_REQ.dat[7]);
	endproperty
	a_fill: assert property (p_fill) else $error("fill level");
	property p_tick; ADC_CLK_EN |=> (!ADC_CLK_EN)[*8]; endproperty
	a_tick: assert property (p_tick) else $error("adc clock fast");
	property p_conv; ADC_SOC |=> s_quiet; endproperty
	a_conv: assert property (p_conv) else $error("early eoc");
	property p_auto;
		up_ff && !AGC_HOLD && !$past(AGC_HOLD) |->
			AGC_GAIN == $past(AGC_AUTO_GAIN);
	endproperty
	a_auto: assert property (p_auto) else $error("gain track");
	property p_rssi;
		up_ff && AGC_HOLD && $past(AGC_HOLD) |-> $stable(RSSI_GAIN);
	endproperty
	a_rssi: assert property (p_rssi) else $error("rssi moved");
	property p_eye; TASK_CFG.eye_mode |=> TASK_CFG.eye_mode; endproperty
	a_eye: assert property (p_eye) else $error("eye left");
endmodule : aas_asserts

// [testbench/test_aux_adc_analog_setup_special_cmd.sv]
// self-checking bench of the aux adc, analogue setup and task block
`timescale 1ns/10ps
module test_aux_adc_analog_setup_special_cmd;
	logic CLK, RST, chf_ovf, hold, wr_ok, gap;
	logic [1:0] auto_g;
	aas_pkg::aas_wb_req_t req;
	logic [31:0] dat;
	logic ack, ram_clr, ram_fill, clk_en, soc, eoc, busy, chf_load;
	logic [1:0] agc_g, rssi_g;
	logic [4:0] i_ofs, q_ofs;
	logic [2:0] chan;
	logic [15:0] ptr;
	aas_pkg::aas_atten_t atten;
	aas_pkg::aas_task_cfg_t cfg;
	aas_pkg::aas_poke_t poke, pk;
	int errors, samples_checked, cyc, t_soc, nload, i;
	logic [7:0] q;
	logic [2:0] chq[$];
	int lat[$];
	logic [7:0] cmds[14] = '{8'h18, 8'h1a, 8'h1a, 8'h1a, 8'h1b, 8'h1c,
		8'h1f, 8'h01, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h15, 8'h1d};
	logic [15:0] w0s[14] = '{16'h1234, 16'h2, 16'h1, 16'h0, 16'h0,
		16'h0abc, 16'h5, 16'h0777, 16'h0, 16'h0, 16'h0, 16'h42, 16'h0, 16'h0};
	logic [31:0] exps[14] = '{32'h1234, 32'h2, 32'h1, 32'h0, 32'h5,
		32'h0abc, 32'h5, 32'h0777, 32'h0100, 32'h0200, 32'h0300,
		32'h425aa5, 32'h1, 32'h1};
	initial begin
		CLK = 0;
		forever #25 CLK = ~CLK;
	end
	aas_top u_dut (.CLK(CLK), .RST(RST), .WB_REQ(req), .WB_DAT_O(dat),
		.WB_ACK_O(ack), .CHF_OVF(chf_ovf), .AGC_HOLD(hold),
		.AGC_AUTO_GAIN(auto_g), .OFS_WR_OK(wr_ok), .OFS_AUTO_VLD(1'b0),
		.OFS_AUTO_I(5'h03), .OFS_AUTO_Q(5'h04), .PROC_GAP(gap),
		.TX_ATTEN(atten), .AGC_GAIN(agc_g), .RSSI_GAIN(rssi_g),
		.RX_I_OFS(i_ofs), .RX_Q_OFS(q_ofs), .RAM_CLR(ram_clr),
		.RAM_FILL(ram_fill), .ADC_CLK_EN(clk_en), .ADC_CHAN(chan),
		.ADC_SOC(soc), .ADC_EOC(eoc), .ADC_BUSY(busy), .TASK_CFG(cfg),
		.FILT_PTR(ptr), .POKE(poke), .CHF_LOAD(chf_load));
	aas_host u_host (.CLK(CLK), .REQ(req), .DAT(dat), .ACK(ack));
	//------------------------------------------------------------
	// monitors and helpers
	//------------------------------------------------------------
	always @(posedge CLK) begin
		cyc++;
		if (soc === 1'b1) begin
			chq.push_back(chan);
			t_soc = cyc;
		end
		if (eoc === 1'b1) lat.push_back(cyc - t_soc);
		if (poke.stb === 1'b1) pk = poke;
		if (chf_load === 1'b1) nload++;
	end
	task automatic chk(input string n, input logic [31:0] e,
			input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] x;
		u_host.xfer(1'b1, a, d, x);
	endtask : wr
	task automatic rd(input logic [5:0] a);
		u_host.xfer(1'b0, a, 8'h00, q);
	endtask : rd
	function automatic logic [31:0] seen(input logic [7:0] c);
		case (c)
			8'h18: seen = 32'(cfg.thresh);
			8'h1a: seen = 32'(cfg.tx_bt);
			8'h1b: seen = 32'({cfg.tx_bt, cfg.rx_bt});
			8'h1c: seen = 32'(cfg.afc_limit);
			8'h1f: seen = 32'(cfg.rssi_avg);
			8'h0c: seen = {pk.addr, pk.data};
			8'h15: seen = 32'(nload);
			8'h1d: seen = 32'(cfg.eye_mode);
			default: seen = 32'(ptr);
		endcase
	endfunction : seen
	task automatic run_cmd(input logic [7:0] c, input logic [15:0] w0);
		wr(aas_pkg::IDX_D0_LO, w0[7:0]);
		wr(aas_pkg::IDX_D0_HI, w0[15:8]);
		wr(aas_pkg::IDX_D1_LO, 8'ha5);
		wr(aas_pkg::IDX_D1_HI, 8'h5a);
		wr(aas_pkg::IDX_TASK_CMD, c);
		rd(aas_pkg::IDX_STATUS);
		chk("pending", 32'({c != 8'h00, 1'b0}), 32'(q[1:0]));
		gap <= 1'b1;
		repeat (3) @(posedge CLK);
		gap <= 1'b0;
		rd(aas_pkg::IDX_STATUS);
		chk("done", 32'(c != 8'h00), 32'(q[0]));
	endtask : run_cmd
	task automatic print_verdict;
		if (errors == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : print_verdict
	initial begin
		#3000000;
		errors++;
		print_verdict;
	end
	//------------------------------------------------------------
	// tests
	//------------------------------------------------------------
	initial begin
		{RST, chf_ovf, hold, wr_ok, gap, auto_g} = 7'h43;
		repeat (8) @(posedge CLK);
		RST <= 1'b0;
		chk("thresh", 32'h0960, 32'(cfg.thresh));
		rd(aas_pkg::IDX_AGC_QOFS);
		chk("s2 rst", 32'hd0, 32'(q));
		chf_ovf <= 1'b1;
		@(posedge CLK) chf_ovf <= 1'b0;
		rd(aas_pkg::IDX_ATT_IOFS);
		chk("ovf", 32'h50, 32'(q));
		rd(aas_pkg::IDX_ATT_IOFS);
		chk("ovf clr", 32'h10, 32'(q));
		wr(aas_pkg::IDX_ATT_IOFS, 8'hc5);
		rd(aas_pkg::IDX_ATT_IOFS);
		chk("ofs lock", 32'h10, 32'(q));
		wr_ok <= 1'b1;
		for (i = 0; i < 4; i++) begin
			wr(aas_pkg::IDX_ATT_IOFS, {i[1:0], 1'b0, 5'(i * 7)});
			repeat (3) @(posedge CLK);
			chk("atten", (i > 1) ? 32'(3 - i) : 32'h2, 32'(atten));
			chk("i ofs", 32'(i * 7), 32'(i_ofs));
		end
		auto_g <= 2'h2;
		repeat (3) @(posedge CLK);
		hold <= 1'b1;
		rd(aas_pkg::IDX_AGC_QOFS);
		chk("saved gain", 32'h2, 32'(q[7:6]));
		wr(aas_pkg::IDX_AGC_QOFS, 8'h5f);
		repeat (3) @(posedge CLK);
		chk("agc", 32'h1, 32'(agc_g));
		chk("rssi", 32'h2, 32'(rssi_g));
		chk("q ofs", 32'h1f, 32'(q_ofs));
		rd(aas_pkg::IDX_AGC_QOFS);
		chk("s2", 32'h5f, 32'(q));
		wr(aas_pkg::IDX_D1_HI, 8'h3c);
		rd(aas_pkg::IDX_D1_HI);
		chk("word1 hi", 32'h3c, 32'(q));
		rd(aas_pkg::IDX_ADC_EN);
		chk("wo read", 32'h0, 32'(q));
		run_cmd(8'h00, 16'h0);
		for (i = 0; i < 14; i++) begin
			run_cmd(cmds[i], w0s[i]);
			chk("task", exps[i], seen(cmds[i]));
		end
		wr(aas_pkg::IDX_ADC_EN, 8'h01);
		wr(aas_pkg::IDX_ADC_CTL, 8'h01);
		for (i = 0; i < 2000 && lat.size() < 1; i++) @(posedge CLK);
		repeat (40) @(posedge CLK);
		chk("first", 32'h1, 32'(lat[0] >= 512 && lat[0] <= 544));
		chk("single end", 32'h0, 32'(busy));
		wr(aas_pkg::IDX_ADC_EN, 8'h21);
		wr(aas_pkg::IDX_ADC_CTL, 8'h07);
		for (i = 0; i < 9000 && lat.size() < 4; i++) @(posedge CLK);
		wr(aas_pkg::IDX_ADC_CTL, 8'hc0);
		@(posedge CLK);
		chk("ram clr", 32'h1, 32'(ram_clr));
		chk("fill", 32'h1, 32'(ram_fill));
		chk("chans", 32'h0028, 32'({chq[0], chq[1], chq[2], chq[3]}));
		chk("later", 32'h1, 32'(lat[2] >= 320 && lat[2] <= 384));
		chk("eye kept", 32'h1, 32'(cfg.eye_mode));
		print_verdict;
	end
endmodule : test_aux_adc_analog_setup_special_cmd
bind aas_top aas_asserts u_chk (.CLK(CLK), .RST(RST), .WB_REQ(WB_REQ),
	.WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .AGC_HOLD(AGC_HOLD),
	.AGC_AUTO_GAIN(AGC_AUTO_GAIN), .AGC_GAIN(AGC_GAIN),
	.RSSI_GAIN(RSSI_GAIN), .RAM_CLR(RAM_CLR), .RAM_FILL(RAM_FILL),
	.ADC_CLK_EN(ADC_CLK_EN), .ADC_SOC(ADC_SOC), .ADC_EOC(ADC_EOC),
	.TASK_CFG(TASK_CFG));
